// file: core/pwr_seq_cfg.svh
`ifndef PWR_SEQ_CFG_SVH
`define PWR_SEQ_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define REG_CTRL        8'h00
`define REG_MODE        8'h04
`define REG_PREDIV      8'h08
`define REG_MULT        8'h0C
`define REG_CLKSEL      8'h10
`define REG_CPUDIV      8'h14
`define REG_USBDIV      8'h18
`define REG_STATUS      8'h1C
`define REG_PGATE       8'h20
`define REG_PDIV_BASE   8'h40

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_PLL_EN     0
`define CTRL_OSC_EN     1
`define ST_LOCK         0
`define ST_OSC_OK       1
`define ST_FLASH_OK     2
`define ST_BROWN_LOW    3
`define ST_RUN          4
`define ST_PLL_ON       5

// ****************************************************************
// limits, reset values and timing
// ****************************************************************
`define PREDIV_MAX      16'd256
`define MULT_MAX        16'd32768
`define CLKSEL_RST      2'd0
`define CLK_MHZ         10
`define RC_WAKE_CYC     4
`define XTAL_WAKE_CYC   4096
`define RC_START_US     60
`define FLASH_WAKE_US   100
`define RST_HOLD_CYC    16
`define FLASH_INIT_CYC  32
`define BOOT_VECTOR     32'h0000_0000

`endif

// file: core/pwr_seq_pkg.sv
package pwr_seq_pkg;
    typedef enum logic [5:0] {
        ST_RESET = 6'b00_0001,
        ST_RUN   = 6'b00_0010,
        ST_IDLE  = 6'b00_0100,
        ST_SLEEP = 6'b00_1000,
        ST_PDOWN = 6'b01_0000,
        ST_WAKE  = 6'b10_0000
    } seq_state_t;
    typedef enum logic [1:0] {
        MODE_RUN   = 2'd0,
        MODE_IDLE  = 2'd1,
        MODE_SLEEP = 2'd2,
        MODE_PDOWN = 2'd3
    } pwr_mode_t;
    typedef enum logic [1:0] {
        SRC_RC   = 2'd0,
        SRC_XTAL = 2'd1,
        SRC_PLL  = 2'd2,
        SRC_RTC  = 2'd3
    } clk_src_t;
endpackage

// file: core/wake_counter.sv
`timescale 1ns/1ps
module wake_counter #(
    parameter int W = 16
) (
    input  wire logic         mclk,   // clock
    input  wire logic         rstn,   // sync reset
    input  wire logic         start,  // load and run
    input  wire logic [W-1:0] count,  // cycles to wait
    output logic              busy,   // counting
    output logic              done    // one-cycle end pulse
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_q <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else if (start) begin
            cnt_q <= count;
            busy  <= 1'b1;
            done  <= 1'b0;
        end else if (busy) begin
            cnt_q <= cnt_q - W'(1);
            busy  <= (cnt_q > W'(1));
            done  <= (cnt_q <= W'(1));
        end else begin
            done  <= 1'b0;
        end
    end
endmodule

// file: core/clk_gate_div.sv
`timescale 1ns/1ps
module clk_gate_div #(
    parameter int W = 8
) (
    input  wire logic         mclk,   // clock
    input  wire logic         rstn,   // sync reset
    input  wire logic         gate,   // clock enabled
    input  wire logic [W-1:0] div,    // divide value minus one
    output logic              tick    // enable pulse for the peripheral
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge mclk) begin
        if (!rstn || !gate) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q >= div) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + W'(1);
            tick  <= 1'b0;
        end
    end
endmodule

// file: core/power_reset_wake_sequencer.sv
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "pwr_seq_cfg.svh"

// Summary of operation
// - pll pre-divider accepts values 1 to 256, others clamped.
// - multiplier accepts 1 to 32768; software keeps oscillator in range.
// - reset and power-down turn pll off and bypass it.
// - after power-up and power-down wake, cpu runs from rc oscillator.
// - crystal start waits for wake-up timer before execution.
// - idle stops cpu only; any interrupt or reset resumes.
// - sleep stops oscillator and all internal clocks, state kept.
// - sleep gates rc output but keeps it powered; rtc runs.
// - sleep disables pll and clears cpu and usb dividers.
// - sleep ends only on reset or clockless wake interrupt.
// - sleep wake waits 4 cycles for rc, 4096 for crystal.
// - power-down adds rc oscillator and flash power off.
// - power-down rc wake waits 60 us start plus 4 cycles.
// - flash wake timer counts 100 us and blocks flash access.
// - four reset sources merge into chip reset.
// - reset held until pin released, count done, flash ready; osc ok is not awaited, as reset clears the osc enable.
// - on release registers hold defaults and fetch starts at address 0.
// - brownout below first threshold raises interrupt and status bit.
// - brownout below second threshold holds chip reset.
// - each peripheral has its own clock gate and divider.
module power_reset_wake_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int NPERIPH        = 4,
    parameter int XTAL_WAKE_CYC  = `XTAL_WAKE_CYC,
    parameter int RC_START_CYC   = (`RC_START_US * `CLK_MHZ),
    parameter int FLASH_WAKE_CYC = (`FLASH_WAKE_US * `CLK_MHZ)
) (
    input  wire logic               mclk,          // system clock
    input  wire logic               rstn,          // sync reset, active low
    input  wire logic [7:0]         addr,          // register byte address
    input  wire logic [31:0]        wdata,         // write data
    input  wire logic               wr,            // write strobe
    input  wire logic               rd,            // read strobe
    output logic [31:0]             rdata,         // read data, cycle after rd
    input  wire logic               ext_rst_n,     // reset pin, active low
    input  wire logic               wdt_rst,       // watchdog reset
    input  wire logic               por,           // power-on detect
    input  wire logic               brown_warn,    // supply below warn level
    input  wire logic               brown_crit,    // supply below reset level
    input  wire logic               osc_ok,        // crystal stable
    input  wire logic               pll_lock,      // pll locked
    input  wire logic               irq_any,       // any pending interrupt
    input  wire logic               irq_wake,      // clockless wake interrupt
    output logic                    chip_rst_n,    // internal reset, active low
    output logic [31:0]             fetch_addr,    // first fetch address
    output logic                    cpu_run,       // cpu clock running
    output logic                    periph_run,    // peripheral clocks running
    output logic [1:0]              cpu_clk_src,   // cpu_clock source
    output logic                    pll_en,        // pll enable
    output logic                    pll_bypass,    // pll bypassed
    output logic [7:0]              pll_prediv,    // n minus one
    output logic [14:0]             pll_mult,      // m minus one
    output logic [7:0]              cpu_div,       // cpu_clock divider
    output logic [7:0]              usb_div,       // usb clock divider
    output logic                    rc_out_en,     // internal_rc_osc output on
    output logic                    rc_pwr,        // internal_rc_osc powered
    output logic                    xtal_en,       // crystal oscillator on
    output logic                    rtc_osc_en,    // rtc oscillator on
    output logic                    flash_pwr,     // flash powered
    output logic                    flash_ok,      // flash access allowed
    output logic                    brown_irq,     // to vector_irq_ctrl
    output logic [NPERIPH-1:0]      periph_tick    // per-peripheral clock enable
);
    seq_state_t     state_q;
    logic           ctrl_pll_q;
    logic           ctrl_osc_q;
    clk_src_t       clksel_q;
    clk_src_t       sleep_src_q;
    logic [7:0]     prediv_q;
    logic [14:0]    mult_q;
    logic [7:0]     cpudiv_q;
    logic [7:0]     usbdiv_q;
    logic [NPERIPH-1:0] pgate_q;
    logic [7:0]     pdiv_q [NPERIPH];
    logic [31:0]    rdata_q;
    logic           flash_ok_q;
    logic           was_pdown_q;
    logic           rst_src;
    logic           sys_rst_n;
    logic           mode_wr;
    pwr_mode_t      mode_req;
    logic           wake_start;
    logic [15:0]    wake_cnt;
    logic           wake_busy;
    logic           wake_done;
    logic           flash_start;
    logic           flash_busy;
    logic           flash_done;
    logic           rst_start;
    logic           rst_busy;
    logic           rst_done;

    // ****************************************************************
    // reset merge
    // ****************************************************************
    // merge four sources
    assign rst_src   = !ext_rst_n || wdt_rst || por || brown_crit;
    assign sys_rst_n = rstn && !rst_src;

    // ****************************************************************
    // register writes
    // ****************************************************************
    assign mode_wr  = wr && (addr == `REG_MODE);
    assign mode_req = pwr_mode_t'(wdata[1:0]);

    always_ff @(posedge mclk) begin
        if (!sys_rst_n) begin
            ctrl_pll_q <= 1'b0;
            ctrl_osc_q <= 1'b0;
            clksel_q   <= clk_src_t'(`CLKSEL_RST);
            prediv_q   <= 8'h00;
            mult_q     <= 15'h0000;
            cpudiv_q   <= 8'h00;
            usbdiv_q   <= 8'h00;
            pgate_q    <= '1;
        end else if (mode_wr && (mode_req == MODE_SLEEP || mode_req == MODE_PDOWN)) begin
            ctrl_pll_q <= 1'b0;
            cpudiv_q   <= 8'h00;
            usbdiv_q   <= 8'h00;
            if (clksel_q == SRC_PLL) begin
                clksel_q <= SRC_RC;
            end
        end else if (state_q == ST_WAKE && was_pdown_q) begin
            clksel_q <= SRC_RC;
        end else if (wr) begin
            if (addr == `REG_CTRL) begin
                ctrl_pll_q <= wdata[`CTRL_PLL_EN];
                ctrl_osc_q <= wdata[`CTRL_OSC_EN];
            end else if (addr == `REG_PREDIV) begin
                prediv_q <= (wdata[15:0] == 16'h0000) ? 8'h00 :
                            (wdata[15:0] > `PREDIV_MAX) ? 8'hFF :
                            8'(wdata[15:0] - 16'h0001);
            end else if (addr == `REG_MULT) begin
                mult_q <= (wdata[16:0] == 17'h0_0000) ? 15'h0000 :
                          (wdata[16:0] > {1'b0, `MULT_MAX}) ? 15'h7FFF :
                          15'(wdata[16:0] - 17'h0_0001);
            end else if (addr == `REG_CLKSEL) begin
                if (clk_src_t'(wdata[1:0]) != SRC_PLL || (ctrl_pll_q && pll_lock)) begin
                    clksel_q <= clk_src_t'(wdata[1:0]);
                end
            end else if (addr == `REG_CPUDIV) begin
                cpudiv_q <= wdata[7:0];
            end else if (addr == `REG_USBDIV) begin
                usbdiv_q <= wdata[7:0];
            end else if (addr == `REG_PGATE) begin
                pgate_q <= wdata[NPERIPH-1:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < NPERIPH; i++) begin
            if (!sys_rst_n) begin
                pdiv_q[i] <= 8'h00;
            end else if (wr && addr == 8'(`REG_PDIV_BASE + 4 * i)) begin
                pdiv_q[i] <= wdata[7:0];
            end
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!sys_rst_n) begin
            state_q     <= ST_RESET;
            sleep_src_q <= SRC_RC;
            was_pdown_q <= 1'b0;
        end else begin
            case (state_q)
                ST_RESET: begin
                    // release after count and flash init
                    if (rst_done) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (mode_wr) begin
                        sleep_src_q <= (clksel_q == SRC_PLL) ? SRC_RC : clksel_q;
                        if (mode_req == MODE_IDLE) begin
                            state_q <= ST_IDLE;
                        end else if (mode_req == MODE_SLEEP) begin
                            state_q     <= ST_SLEEP;
                            was_pdown_q <= 1'b0;
                        end else if (mode_req == MODE_PDOWN) begin
                            state_q     <= ST_PDOWN;
                            was_pdown_q <= 1'b1;
                        end
                    end
                end
                ST_IDLE: begin
                    if (irq_any) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_SLEEP, ST_PDOWN: begin
                    if (irq_wake) begin
                        state_q <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (wake_done) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RESET;
                end
            endcase
        end
    end

    // ****************************************************************
    // wake-up timers
    // ****************************************************************
    // crystal waits long count
    assign wake_start = (state_q == ST_SLEEP || state_q == ST_PDOWN) && irq_wake;
    assign wake_cnt   = (sleep_src_q == SRC_RC && !was_pdown_q) ? 16'(`RC_WAKE_CYC) :
                        (sleep_src_q == SRC_RC) ? 16'(RC_START_CYC + `RC_WAKE_CYC) :
                        16'(XTAL_WAKE_CYC);

    wake_counter #(.W(16)) u_wake (
        .mclk  (mclk),
        .rstn  (sys_rst_n),
        .start (wake_start),
        .count (wake_cnt),
        .busy  (wake_busy),
        .done  (wake_done)
    );

    assign flash_start = wake_start && state_q == ST_PDOWN;

    wake_counter #(.W(16)) u_flash (
        .mclk  (mclk),
        .rstn  (sys_rst_n),
        .start (flash_start),
        .count (16'(FLASH_WAKE_CYC)),
        .busy  (flash_busy),
        .done  (flash_done)
    );

    logic rst_arm_q;
    always_ff @(posedge mclk) begin
        if (!sys_rst_n) begin
            rst_arm_q <= 1'b1;
        end else if (rst_start) begin
            rst_arm_q <= 1'b0;
        end
    end
    assign rst_start = rst_arm_q && (!ctrl_osc_q || osc_ok);

    wake_counter #(.W(16)) u_rst (
        .mclk  (mclk),
        .rstn  (sys_rst_n),
        .start (rst_start),
        .count (16'(`RST_HOLD_CYC + `FLASH_INIT_CYC)),
        .busy  (rst_busy),
        .done  (rst_done)
    );

    always_ff @(posedge mclk) begin
        if (!sys_rst_n) begin
            flash_ok_q <= 1'b0;
        end else if (state_q == ST_PDOWN) begin
            flash_ok_q <= 1'b0;
        end else if (rst_done || flash_done) begin
            flash_ok_q <= 1'b1;
        end
    end

    // ****************************************************************
    // peripheral clocks
    // ****************************************************************
    // gate and divider each
    for (genvar g = 0; g < NPERIPH; g++) begin : g_per
        clk_gate_div #(.W(8)) u_div (
            .mclk (mclk),
            .rstn (sys_rst_n),
            .gate (pgate_q[g] && periph_run),
            .div  (pdiv_q[g]),
            .tick (periph_tick[g])
        );
    end

    // ****************************************************************
    // outputs and read-back
    // ****************************************************************
    logic asleep;
    assign asleep = state_q == ST_SLEEP || state_q == ST_PDOWN || state_q == ST_WAKE;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            chip_rst_n  <= 1'b0;
            cpu_run     <= 1'b0;
            periph_run  <= 1'b0;
            rc_out_en   <= 1'b1;
            rc_pwr      <= 1'b1;
            xtal_en     <= 1'b0;
            flash_pwr   <= 1'b1;
            pll_en      <= 1'b0;
            pll_bypass  <= 1'b1;
            cpu_clk_src <= 2'd0;
            pll_prediv  <= 8'h00;
            pll_mult    <= 15'h0000;
            cpu_div     <= 8'h00;
            usb_div     <= 8'h00;
            fetch_addr  <= `BOOT_VECTOR;
            flash_ok    <= 1'b0;
            brown_irq   <= 1'b0;
        end else begin
            chip_rst_n  <= sys_rst_n && state_q != ST_RESET;
            cpu_run     <= state_q == ST_RUN;
            periph_run  <= state_q == ST_RUN || state_q == ST_IDLE;
            rc_out_en   <= !asleep;
            rc_pwr      <= state_q != ST_PDOWN;
            flash_pwr   <= state_q != ST_PDOWN;
            xtal_en     <= ctrl_osc_q && !(state_q == ST_SLEEP || state_q == ST_PDOWN);
            pll_en      <= ctrl_pll_q && sys_rst_n;
            pll_bypass  <= !(ctrl_pll_q && clksel_q == SRC_PLL);
            cpu_clk_src <= clksel_q;
            pll_prediv  <= prediv_q;
            pll_mult    <= mult_q;
            cpu_div     <= cpudiv_q;
            usb_div     <= usbdiv_q;
            fetch_addr  <= `BOOT_VECTOR;
            flash_ok    <= flash_ok_q && state_q != ST_PDOWN;
            brown_irq   <= brown_warn;
        end
    end

    assign rtc_osc_en = 1'b1;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd) begin
            if (addr == `REG_CTRL) begin
                rdata_q <= {30'h0, ctrl_osc_q, ctrl_pll_q};
            end else if (addr == `REG_PREDIV) begin
                rdata_q <= {23'h0, 9'(prediv_q) + 9'h001};
            end else if (addr == `REG_MULT) begin
                rdata_q <= {16'h0, 16'(mult_q) + 16'h0001};
            end else if (addr == `REG_CLKSEL) begin
                rdata_q <= {30'h0, clksel_q};
            end else if (addr == `REG_CPUDIV) begin
                rdata_q <= {24'h0, cpudiv_q};
            end else if (addr == `REG_USBDIV) begin
                rdata_q <= {24'h0, usbdiv_q};
            end else if (addr == `REG_PGATE) begin
                rdata_q <= 32'(pgate_q);
            end else if (addr == `REG_STATUS) begin
                rdata_q <= {26'h0, pll_en, state_q == ST_RUN, brown_warn,
                            flash_ok_q, osc_ok, pll_lock};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign rdata = rdata_q;
endmodule

// file: test/pwr_seq_asserts.sv
`timescale 1ns/1ps
module pwr_seq_asserts (
    input  wire logic        mclk,        // clock
    input  wire logic        rstn,        // reset
    input  wire logic        ext_rst_n,   // pin reset
    input  wire logic        wdt_rst,     // watchdog
    input  wire logic        por,         // power-on
    input  wire logic        brown_warn,  // warn level
    input  wire logic        brown_crit,  // reset level
    input  wire logic        irq_wake,    // wake irq
    input  wire logic        chip_rst_n,  // internal reset
    input  wire logic [31:0] fetch_addr,  // first fetch
    input  wire logic        cpu_run,     // cpu clocked
    input  wire logic        periph_run,  // periph clocked
    input  wire logic [1:0]  cpu_clk_src, // source
    input  wire logic        pll_en,      // pll on
    input  wire logic        pll_bypass,  // bypass
    input  wire logic [7:0]  cpu_div,     // cpu div
    input  wire logic [7:0]  usb_div,     // usb div
    input  wire logic        rc_out_en,   // rc out
    input  wire logic        rc_pwr,      // rc power
    input  wire logic        rtc_osc_en,  // rtc osc
    input  wire logic        flash_pwr,   // flash power
    input  wire logic        flash_ok,    // flash usable
    input  wire logic        brown_irq    // brownout irq
);
    logic [7:0] rel_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // cycles since all reset sources let go
    always_ff @(posedge mclk) begin
        if (!rstn || !ext_rst_n || wdt_rst || por || brown_crit) begin
            rel_q <= 8'h00;
        end else if (rel_q != 8'hFF) begin
            rel_q <= rel_q + 8'h01;
        end
    end
    property p_rst_pll; !chip_rst_n |-> !pll_en && pll_bypass; endproperty
    a_rst_pll: assert property (p_rst_pll) else $error("pll on in reset");
    property p_merge; !ext_rst_n || wdt_rst || por |=> !chip_rst_n; endproperty
    a_merge: assert property (p_merge) else $error("source missed");
    property p_crit; brown_crit |=> !chip_rst_n; endproperty
    a_crit: assert property (p_crit) else $error("brownout reset missed");
    property p_hold; $rose(chip_rst_n) |-> rel_q >= 8'd46; endproperty
    a_hold: assert property (p_hold) else $error("reset released early");
    property p_fetch; $rose(chip_rst_n) |-> fetch_addr == 32'h0000_0000; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch not at zero");
    property p_brown; 1'b1 |=> brown_irq == $past(brown_warn); endproperty
    a_brown: assert property (p_brown) else $error("brownout irq wrong");
    property p_rc_gate; !rc_out_en && rc_pwr |-> rtc_osc_en && !cpu_run; endproperty
    a_rc_gate: assert property (p_rc_gate) else $error("sleep clocks wrong");
    property p_pdown; !rc_pwr |-> !flash_pwr && !flash_ok && !cpu_run; endproperty
    a_pdown: assert property (p_pdown) else $error("pdown flash on");
    property p_sleep_div;
        $fell(periph_run) |-> cpu_div == 8'h00 && usb_div == 8'h00 && !pll_en;
    endproperty
    a_sleep_div: assert property (p_sleep_div) else $error("dividers kept");
    property p_rc_wake;
        $rose(irq_wake) && !periph_run && rc_pwr && chip_rst_n && cpu_clk_src == 2'h0
            |-> !cpu_run [*4] ##[1:4] cpu_run;
    endproperty
    a_rc_wake: assert property (p_rc_wake) else $error("rc wake timing");
    c_wake: cover property ($rose(irq_wake) && !periph_run);
    c_rel: cover property ($rose(chip_rst_n));
    c_brown: cover property ($rose(brown_irq));
endmodule

// file: test/clk_src_model.sv
`timescale 1ns/1ps
module clk_src_model (
    input  wire logic mclk,     // clock
    input  wire logic pll_en,   // pll enable
    input  wire logic xtal_en,  // crystal on
    output logic      pll_lock, // lock flag
    output logic      osc_ok    // crystal stable
);
    logic [2:0] lk_q = 3'h0;
    logic [2:0] ok_q = 3'h0;
    always_ff @(posedge mclk) lk_q <= {lk_q[1:0], pll_en};
    assign pll_lock = &lk_q && pll_en;
    always_ff @(posedge mclk) ok_q <= {ok_q[1:0], xtal_en};
    assign osc_ok = &ok_q && xtal_en;
endmodule

// file: test/power_reset_wake_sequencer_tb.sv
`timescale 1ns/1ps
module power_reset_wake_sequencer_tb;
    import pwr_seq_pkg::*;
    logic        mclk, rstn, wr, rd, brown_warn, irq_any, irq_wake, osc_ok, pll_lock;
    logic        chip_rst_n, cpu_run, periph_run, pll_en, pll_bypass, rc_out_en, rc_pwr;
    logic        xtal_en, rtc_osc_en, flash_pwr, flash_ok, brown_irq;
    logic [1:0]  cpu_clk_src;
    logic [3:0]  rsrc, periph_tick;
    logic [7:0]  addr, pll_prediv, cpu_div, usb_div;
    logic [14:0] pll_mult;
    logic [31:0] wdata, rdata, fetch_addr, r;
    int          fail_count, n_tests, n, i;
    logic [7:0]  ca[4] = '{8'h08, 8'h08, 8'h0C, 8'h0C};
    logic [31:0] cw[4] = '{32'h0000_0000, 32'h0000_012C, 32'h0000_0000, 32'h0000_9C40};
    logic [31:0] ce[4] = '{32'h0000_0001, 32'h0000_0100, 32'h0000_0001, 32'h0000_8000};
    power_reset_wake_sequencer #(.XTAL_WAKE_CYC(16), .FLASH_WAKE_CYC(20))
        power_reset_wake_sequencer_inst (.*, .ext_rst_n(~rsrc[0]), .wdt_rst(rsrc[1]),
        .por(rsrc[2]), .brown_crit(rsrc[3]));
    clk_src_model clk_src_model_inst (.*);
    always #50 mclk = ~mclk;
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    // bounded wait: 0 reset release, 1 cpu running, 2 pll lock
    task automatic wait_for(input int s, input int lim, output int c);
        logic [2:0] w;
        c = 0;
        do begin
            @(posedge mclk);
            #1 c++;
            w = {pll_lock, cpu_run, chip_rst_n};
        end while (w[s] !== 1'b1 && c < lim);
        if (w[s] !== 1'b1) begin
            fail_count++;
            $display("[FAIL] wait %0d exp 1 got 0", s);
            tally_and_finish;
        end
    endtask
    task automatic wake_chk(input int e, input string nm);
        irq_any <= 1'b1;
        settle;
        chk("no wake on irq", 1'h0, cpu_run);
        irq_any <= 1'b0;
        irq_wake <= 1'b1;
        wait_for(1, e + 10, n);
        irq_wake <= 1'b0;
        chk(nm, 1'h1, n >= e + 1 && n <= e + 5);
    endtask
    task automatic ticks(output int t);
        t = 0;
        repeat (16) begin
            @(posedge mclk);
            #1 t += periph_tick[0];
        end
    endtask
    initial begin
        mclk = 0; rstn = 0; wr = 0; rd = 0; addr = 0; wdata = 0; rsrc = 0;
        brown_warn = 0; irq_any = 0; irq_wake = 0; fail_count = 0; n_tests = 0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        wait_for(0, 100, n);
        chk("fetch_addr", 32'h0000_0000, fetch_addr);
        chk("cpu_clk_src", SRC_RC, cpu_clk_src);
        chk("pll en,bypass", 2'h1, {pll_en, pll_bypass});
        for (i = 0; i < 4; i++) begin
            rsrc <= 4'h1 << i;
            repeat (2) @(posedge mclk);
            rsrc <= 4'h0;
            #1 chk("chip_rst_n", 1'h0, chip_rst_n);
            wait_for(0, 100, n);
            chk("reset hold", 1'h1, n >= 48 && n <= 56);
        end
        $display("reset test done");
        for (i = 0; i < 4; i++) begin
            wr_reg(ca[i], cw[i]);
            rd_reg(ca[i], r);
            chk("n,m clamp", ce[i], r);
        end
        chk("n,m ports", 23'h7F_FFFF, {pll_prediv, pll_mult});
        wr_reg(8'h10, 32'h0000_0002);
        rd_reg(8'h10, r);
        chk("early pll select", 32'h0000_0000, r);
        wr_reg(8'h00, 32'h0000_0001);
        wait_for(2, 20, n);
        wr_reg(8'h10, 32'h0000_0002);
        wr_reg(8'h14, 32'h0000_0005);
        chk("pll select", SRC_PLL, cpu_clk_src);
        $display("pll test done");
        wr_reg(8'h04, 32'h0000_0002);
        settle;
        chk("sleep outputs", 32'h0000_0004, {pll_en, cpu_div, usb_div, cpu_clk_src,
            rc_out_en, rc_pwr, cpu_run, periph_run});
        wake_chk(4, "rc sleep wake");
        wr_reg(8'h04, 32'h0000_0001);
        settle;
        chk("idle run", 2'h1, {cpu_run, periph_run});
        irq_any <= 1'b1;
        wait_for(1, 8, n);
        irq_any <= 1'b0;
        wr_reg(8'h00, 32'h0000_0002);
        wr_reg(8'h10, 32'h0000_0001);
        wr_reg(8'h04, 32'h0000_0002);
        settle;
        wake_chk(16, "xtal sleep wake");
        wr_reg(8'h10, 32'h0000_0000);
        wr_reg(8'h04, 32'h0000_0003);
        settle;
        chk("pdown", 6'h00, {xtal_en, rc_pwr, rc_out_en, flash_pwr, flash_ok, cpu_run});
        wake_chk(604, "pdown wake");
        chk("flash_ok", 1'h1, flash_ok);
        $display("mode test done");
        brown_warn <= 1'b1;
        settle;
        rd_reg(8'h1C, r);
        chk("brownout status,irq", 2'h3, {r[3], brown_irq});
        brown_warn <= 1'b0;
        rd_reg(8'h20, r);
        chk("gate reset", 4'hF, r[3:0]);
        wr_reg(8'h40, 32'h0000_0003);
        ticks(n);
        chk("tick rate", 32'h0000_0004, n);
        wr_reg(8'h20, 32'h0000_0000);
        ticks(n);
        chk("tick gated", 32'h0000_0000, n);
        rd_reg(8'h80, r);
        chk("unmapped read", 32'h0000_0000, r);
        $display("misc test done");
        tally_and_finish;
    end
endmodule
bind power_reset_wake_sequencer pwr_seq_asserts pwr_seq_asserts_inst (.*);
